/* logic/pmcr_pkg.sv */
// Constants for the multiplier configuration register bank
package pmcr_pkg;
  localparam logic [7:0] PMCR_ADDR_DEV_CTRL = 8'h02;
  localparam logic [7:0] PMCR_ADDR_DEV_CFG1 = 8'h03;
  localparam logic [7:0] PMCR_ADDR_DEV_CFG2 = 8'h04;
  localparam logic [7:0] PMCR_ADDR_GLOBAL = 8'h05;
  localparam logic [7:0] PMCR_ADDR_RATIO0 = 8'h06;
  localparam logic [7:0] PMCR_ADDR_RATIO1 = 8'h07;
  localparam logic [7:0] PMCR_ADDR_RATIO2 = 8'h08;
  localparam logic [7:0] PMCR_ADDR_RATIO3 = 8'h09;
  localparam logic [7:0] PMCR_ADDR_FUNC1 = 8'h16;
  localparam logic [7:0] PMCR_ADDR_FUNC2 = 8'h17;
  localparam logic [7:0] PMCR_ADDR_FUNC3 = 8'h1E;
  // Writable bits of each register; reserved bits are never stored
  localparam logic [7:0] PMCR_MASK_DEV_CTRL = 8'h03;
  localparam logic [7:0] PMCR_MASK_DEV_CFG1 = 8'hE7;
  localparam logic [7:0] PMCR_MASK_DEV_CFG2 = 8'hFF;
  localparam logic [7:0] PMCR_MASK_GLOBAL = 8'h09;
  localparam logic [7:0] PMCR_MASK_FUNC1 = 8'hD8;
  localparam logic [7:0] PMCR_MASK_FUNC2 = 8'h18;
  localparam logic [7:0] PMCR_MASK_FUNC3 = 8'h70;
  localparam logic [7:0] PMCR_RST_BYTE = 8'h00;
  localparam logic [31:0] PMCR_RST_RATIO = 32'h0000_0000;
  // Field positions
  localparam int PMCR_UNLOCK_BIT = 7;
  localparam int PMCR_AUX_DIS_BIT = 1;
  localparam int PMCR_CLK_DIS_BIT = 0;
  localparam int PMCR_PORT_EN1_BIT = 0;
  localparam int PMCR_AUX_SRC_LSB = 1;
  localparam int PMCR_RMOD_LSB = 5;
  localparam int PMCR_HOLD_BIT = 3;
  localparam int PMCR_PORT_EN2_BIT = 0;
  localparam int PMCR_SKIP_BIT = 7;
  localparam int PMCR_LOCK_STYLE_BIT = 6;
  localparam int PMCR_PREDIV_LSB = 3;
  localparam int PMCR_UNL_OUT_BIT = 4;
  localparam int PMCR_FORMAT_BIT = 3;
  localparam int PMCR_BW_LSB = 4;
  typedef enum logic [1:0] {
    PMCR_AUX_REF = 2'h0,
    PMCR_AUX_FREQ_IN = 2'h1,
    PMCR_AUX_PLL_OUT = 2'h2,
    PMCR_AUX_LOCK = 2'h3
  } pmcr_aux_src_t;
  typedef enum logic [1:0] {
    PMCR_DIV_BY4 = 2'h0,
    PMCR_DIV_BY2 = 2'h1,
    PMCR_DIV_BY1 = 2'h2,
    PMCR_DIV_RSVD = 2'h3
  } pmcr_prediv_t;
  // Reference edges counted per output tick, minus one
  localparam logic [1:0] PMCR_DIV4_LAST = 2'h3;
  localparam logic [1:0] PMCR_DIV2_LAST = 2'h1;
  localparam logic [1:0] PMCR_DIV1_LAST = 2'h0;
  localparam logic PMCR_FMT_20_12 = 1'b0;
  localparam logic PMCR_FMT_12_20 = 1'b1;
endpackage

/* logic/pmcr_ref_divider.sv */
// Reference pre-divider: one tick per 4, 2 or 1 reference edges
`timescale 1ns/1ps
module pmcr_ref_divider (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control
  input wire pmcr_pkg::pmcr_prediv_t div_code,
  input wire logic ref_edge,
  // Result
  output logic div_tick,
  output logic div_level,
  output logic div_code_bad
);
  import pmcr_pkg::*;

  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic [1:0] last_count;
  logic tick_next;
  logic level_reg;
  logic tick_reg;

  assign last_count = (div_code == PMCR_DIV_BY4) ? PMCR_DIV4_LAST :
                      (div_code == PMCR_DIV_BY2) ? PMCR_DIV2_LAST : PMCR_DIV1_LAST;
  // Reserved code stops the divider rather than guessing a ratio
  assign div_code_bad = (div_code == PMCR_DIV_RSVD);
  assign tick_next = ref_edge && !div_code_bad && (cnt_reg >= last_count);
  assign cnt_next = (tick_next || div_code_bad) ? 2'h0 :
                    (ref_edge ? cnt_reg + 2'h1 : cnt_reg);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt_reg <= 2'h0;
      tick_reg <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
      level_reg <= level_reg ^ tick_next;
    end
  end

  assign div_tick = tick_reg;
  assign div_level = level_reg;

  a_div_by_four: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (div_code == PMCR_DIV_BY4 && ref_edge && cnt_reg == 2'h1) |=> !div_tick)
    else $error("divide by four ticked early");
  a_div_by_one: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (div_code == PMCR_DIV_BY1 && ref_edge) |=> div_tick)
    else $error("divide by one missed a tick");
  a_div_code_stop: assert property (@(posedge sys_clk) disable iff (sys_rst)
    div_code_bad |=> !div_tick)
    else $error("reserved divider code still ticked");
endmodule // pmcr_ref_divider

/* logic/pmcr_config_regs.sv */
// Configuration register bank of the fractional-N multiplier
`timescale 1ns/1ps
module pmcr_config_regs (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Byte access from the serial control port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic port_four_wire,
  input wire logic chip_addr_seen,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  // Loop status and clock levels
  input wire logic pll_unlocked,
  input wire logic ref_clk_in,
  input wire logic freq_ref_in,
  input wire logic pll_clk_in,
  // Settings towards the loop
  output logic [31:0] ratio_value,
  output logic ratio_format_select,
  output logic skip_mode_on,
  output logic [2:0] min_loop_bw,
  output logic [2:0] loop_bw_applied,
  output logic [2:0] rmod_select,
  output logic ref_div_tick,
  output logic ref_div_code_bad,
  output logic hold_active,
  output logic control_port_mode,
  // Pins
  output logic aux_out_o,
  output logic aux_out_oe_n,
  output logic clk_out_o,
  output logic clk_out_oe_n
);
  import pmcr_pkg::*;

  logic [7:0] ctrl_pend_reg, cfg1_pend_reg, cfg2_pend_reg;
  logic [7:0] ctrl_act_reg, cfg1_act_reg, cfg2_act_reg;
  logic [7:0] ctrl_pend_next, cfg1_pend_next, cfg2_pend_next;
  logic [7:0] global_reg, func1_reg, func2_reg, func3_reg;
  logic [31:0] ratio_reg;
  logic [2:0] bw_applied_reg;
  logic seen_reg, mode_reg;
  logic hold_next;
  logic [7:0] rdata_reg;
  logic rd_valid_reg;
  logic ref_clk_q, ref_edge;
  logic div_level;
  logic aux_o_reg, aux_oe_n_reg, clk_o_reg, clk_oe_n_reg;
  logic aux_o_next, aux_oe_n_next, clk_o_next, clk_oe_n_next;
  logic [7:0] rd_mux;

  // Write decode
  wire wr_ctrl = reg_wr && reg_addr == PMCR_ADDR_DEV_CTRL;
  wire wr_cfg1 = reg_wr && reg_addr == PMCR_ADDR_DEV_CFG1;
  wire wr_cfg2 = reg_wr && reg_addr == PMCR_ADDR_DEV_CFG2;
  wire wr_global = reg_wr && reg_addr == PMCR_ADDR_GLOBAL;
  wire wr_func1 = reg_wr && reg_addr == PMCR_ADDR_FUNC1;
  wire wr_func2 = reg_wr && reg_addr == PMCR_ADDR_FUNC2;
  wire wr_func3 = reg_wr && reg_addr == PMCR_ADDR_FUNC3;
  wire [3:0] wr_ratio = {reg_wr && reg_addr == PMCR_ADDR_RATIO0,
                         reg_wr && reg_addr == PMCR_ADDR_RATIO1,
                         reg_wr && reg_addr == PMCR_ADDR_RATIO2,
                         reg_wr && reg_addr == PMCR_ADDR_RATIO3};

  // Reserved bits are dropped, so stray writes there cannot reach the loop
  wire [7:0] wdata_ctrl = reg_wdata & PMCR_MASK_DEV_CTRL;
  wire [7:0] wdata_cfg1 = reg_wdata & PMCR_MASK_DEV_CFG1;
  wire [7:0] wdata_cfg2 = reg_wdata & PMCR_MASK_DEV_CFG2;

  assign ctrl_pend_next = wr_ctrl ? wdata_ctrl : ctrl_pend_reg;
  assign cfg1_pend_next = wr_cfg1 ? wdata_cfg1 : cfg1_pend_reg;
  assign cfg2_pend_next = wr_cfg2 ? wdata_cfg2 : cfg2_pend_reg;
  assign hold_next = wr_global ? reg_wdata[PMCR_HOLD_BIT] : global_reg[PMCR_HOLD_BIT];

  // Pending and active copies of 02h-04h
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_pend_reg <= PMCR_RST_BYTE;
      cfg1_pend_reg <= PMCR_RST_BYTE;
      cfg2_pend_reg <= PMCR_RST_BYTE;
      ctrl_act_reg <= PMCR_RST_BYTE;
      cfg1_act_reg <= PMCR_RST_BYTE;
      cfg2_act_reg <= PMCR_RST_BYTE;
    end else begin
      ctrl_pend_reg <= ctrl_pend_next;
      cfg1_pend_reg <= cfg1_pend_next;
      cfg2_pend_reg <= cfg2_pend_next;
      // A write landing with hold off, or hold released, applies all at once
      if (!hold_next) begin
        ctrl_act_reg <= ctrl_pend_next;
        cfg1_act_reg <= cfg1_pend_next;
        cfg2_act_reg <= cfg2_pend_next;
      end
    end
  end

  // Global and function registers take effect directly
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      global_reg <= PMCR_RST_BYTE;
      func1_reg <= PMCR_RST_BYTE;
      func2_reg <= PMCR_RST_BYTE;
      func3_reg <= PMCR_RST_BYTE;
      ratio_reg <= PMCR_RST_RATIO;
    end else begin
      if (wr_global) global_reg <= reg_wdata & PMCR_MASK_GLOBAL;
      if (wr_func1) func1_reg <= reg_wdata & PMCR_MASK_FUNC1;
      if (wr_func2) func2_reg <= reg_wdata & PMCR_MASK_FUNC2;
      if (wr_func3) func3_reg <= reg_wdata & PMCR_MASK_FUNC3;
      for (int i = 0; i < 4; i++) begin
        if (wr_ratio[i]) ratio_reg[8*i +: 8] <= reg_wdata;
      end
    end
  end

  // Bandwidth reaches the loop only while it is unlocked
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bw_applied_reg <= 3'h0;
    end else if (pll_unlocked) begin
      bw_applied_reg <= func3_reg[PMCR_BW_LSB +: 3];
    end
  end

  // Port mode; the address flag is sticky until reset
  wire mode_next = seen_reg && cfg1_act_reg[PMCR_PORT_EN1_BIT]
                   && global_reg[PMCR_PORT_EN2_BIT];
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      seen_reg <= 1'b0;
      mode_reg <= 1'b0;
    end else begin
      seen_reg <= seen_reg | chip_addr_seen;
      mode_reg <= mode_next;
    end
  end

  // Read mux; the unlock flag is live status
  always_comb begin
    case (reg_addr)
      PMCR_ADDR_DEV_CTRL: rd_mux = {pll_unlocked, 5'h00, ctrl_pend_reg[1:0]};
      PMCR_ADDR_DEV_CFG1: rd_mux = cfg1_pend_reg;
      PMCR_ADDR_DEV_CFG2: rd_mux = cfg2_pend_reg;
      PMCR_ADDR_GLOBAL: rd_mux = global_reg;
      PMCR_ADDR_RATIO0: rd_mux = ratio_reg[31:24];
      PMCR_ADDR_RATIO1: rd_mux = ratio_reg[23:16];
      PMCR_ADDR_RATIO2: rd_mux = ratio_reg[15:8];
      PMCR_ADDR_RATIO3: rd_mux = ratio_reg[7:0];
      PMCR_ADDR_FUNC1: rd_mux = func1_reg;
      PMCR_ADDR_FUNC2: rd_mux = func2_reg;
      PMCR_ADDR_FUNC3: rd_mux = func3_reg;
      default: rd_mux = 8'h00;
    endcase
  end

  // Four-wire reads get no answer at all
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= reg_rd && !port_four_wire;
      if (reg_rd && !port_four_wire) rdata_reg <= rd_mux;
    end
  end

  // Reference pre-divider
  always_ff @(posedge sys_clk) begin
    if (sys_rst) ref_clk_q <= 1'b0;
    else ref_clk_q <= ref_clk_in;
  end
  assign ref_edge = ref_clk_in && !ref_clk_q;

  pmcr_ref_divider u_prediv (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .div_code(pmcr_prediv_t'(func1_reg[PMCR_PREDIV_LSB +: 2])),
    .ref_edge(ref_edge),
    .div_tick(ref_div_tick),
    .div_level(div_level),
    .div_code_bad(ref_div_code_bad)
  );

  // Pin drive
  wire pmcr_aux_src_t aux_src = pmcr_aux_src_t'(cfg1_act_reg[PMCR_AUX_SRC_LSB +: 2]);
  wire lock_style = func1_reg[PMCR_LOCK_STYLE_BIT];
  wire unl_run = func2_reg[PMCR_UNL_OUT_BIT];
  always_comb begin
    aux_o_next = 1'b0;
    aux_oe_n_next = 1'b0;
    case (aux_src)
      PMCR_AUX_REF: aux_o_next = div_level;
      PMCR_AUX_FREQ_IN: aux_o_next = freq_ref_in;
      PMCR_AUX_PLL_OUT: aux_o_next = clk_o_next;
      PMCR_AUX_LOCK: begin
        if (lock_style) begin
          aux_o_next = 1'b0;
          aux_oe_n_next = !pll_unlocked;
        end else begin
          aux_o_next = pll_unlocked;
        end
      end
      default: aux_o_next = 1'b0;
    endcase
    if (ctrl_act_reg[PMCR_AUX_DIS_BIT]) aux_oe_n_next = 1'b1;
  end
  // Unlocked output is whatever the loop gives when running is allowed
  assign clk_o_next = pll_clk_in && (unl_run || !pll_unlocked);
  assign clk_oe_n_next = ctrl_act_reg[PMCR_CLK_DIS_BIT];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aux_o_reg <= 1'b0;
      aux_oe_n_reg <= 1'b1;
      clk_o_reg <= 1'b0;
      clk_oe_n_reg <= 1'b1;
    end else begin
      aux_o_reg <= aux_o_next;
      aux_oe_n_reg <= aux_oe_n_next;
      clk_o_reg <= clk_o_next;
      clk_oe_n_reg <= clk_oe_n_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign ratio_value = ratio_reg;
  assign ratio_format_select = func2_reg[PMCR_FORMAT_BIT];
  assign skip_mode_on = func1_reg[PMCR_SKIP_BIT];
  assign min_loop_bw = func3_reg[PMCR_BW_LSB +: 3];
  assign loop_bw_applied = bw_applied_reg;
  assign rmod_select = cfg1_act_reg[PMCR_RMOD_LSB +: 3];
  assign hold_active = global_reg[PMCR_HOLD_BIT];
  assign control_port_mode = mode_reg;
  assign aux_out_o = aux_o_reg;
  assign aux_out_oe_n = aux_oe_n_reg;
  assign clk_out_o = clk_o_reg;
  assign clk_out_oe_n = clk_oe_n_reg;

  // Checks
  sequence s_held_write;
    hold_active && hold_next && wr_cfg1;
  endsequence
  sequence s_release;
    hold_active && !hold_next;
  endsequence

  a_hold_keeps_active: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_held_write |=> $stable(cfg1_act_reg))
    else $error("active config changed under hold");
  a_direct_apply: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!hold_next && wr_cfg1) |=> cfg1_act_reg == $past(wdata_cfg1))
    else $error("write with hold clear not applied");
  a_release_copy: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_release |=> (ctrl_act_reg == ctrl_pend_reg && cfg1_act_reg == cfg1_pend_reg
                   && cfg2_act_reg == cfg2_pend_reg))
    else $error("hold release left a partial update");
  a_port_mode_gate: assert property (@(posedge sys_clk) disable iff (sys_rst)
    control_port_mode |-> ($past(seen_reg) && $past(cfg1_act_reg[PMCR_PORT_EN1_BIT])
                           && $past(global_reg[PMCR_PORT_EN2_BIT])))
    else $error("port mode without address and both enables");
  a_ratio_msb_first: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_ratio[3] |=> ratio_value[31:24] == $past(reg_wdata))
    else $error("lowest ratio address not most significant");
  a_aux_push_pull: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (aux_src == PMCR_AUX_LOCK && !lock_style && !ctrl_act_reg[PMCR_AUX_DIS_BIT])
    |=> (aux_out_o == $past(pll_unlocked) && !aux_out_oe_n))
    else $error("push-pull unlock indicator wrong");
  a_aux_open_drain: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (aux_src == PMCR_AUX_LOCK && lock_style && !ctrl_act_reg[PMCR_AUX_DIS_BIT])
    |=> (!aux_out_o && aux_out_oe_n == !$past(pll_unlocked)))
    else $error("open-drain unlock indicator wrong");
  a_clk_low_unlock: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!unl_run && pll_unlocked) |=> !clk_out_o)
    else $error("clock ran while unlocked");
  a_bw_locked_stable: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !pll_unlocked |=> $stable(loop_bw_applied))
    else $error("bandwidth changed while locked");
  a_four_wire_silent: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (reg_rd && port_four_wire) |=> !reg_rd_valid)
    else $error("four-wire read answered");
  a_two_wire_answer: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (reg_rd && !port_four_wire) |=> (reg_rd_valid && reg_rdata == $past(rd_mux)))
    else $error("two-wire read not answered");
  a_hold_ctrl_kept: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (hold_active && hold_next && wr_ctrl) |=> $stable(ctrl_act_reg))
    else $error("active control changed under hold");
  a_clk_disable: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ctrl_act_reg[PMCR_CLK_DIS_BIT] |=> clk_out_oe_n)
    else $error("clock pin driven while disabled");
  a_aux_style_ignored: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (aux_src != PMCR_AUX_LOCK && !ctrl_act_reg[PMCR_AUX_DIS_BIT]) |=> !aux_out_oe_n)
    else $error("lock style touched a clock source");
  a_clk_run_unlock: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (unl_run && pll_unlocked) |=> clk_out_o == $past(pll_clk_in))
    else $error("clock stopped while running was allowed");
  a_bw_follow_unlocked: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pll_unlocked |=> loop_bw_applied == $past(min_loop_bw))
    else $error("bandwidth not applied while unlocked");
endmodule // pmcr_config_regs

/* test/pmcr_host_model.sv */
// Host controller model issuing byte writes and reads on the register port
`timescale 1ns/1ps
module pmcr_host_model (
  // Clock
  input wire logic sys_clk,
  // Requests towards the bank
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic port_four_wire,
  // Read answer
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    port_four_wire = 1'b0;
  end
  // Idle lines show the inverse so a stale byte never passes for fresh
  task automatic release_bus();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
  endtask
  // Callers keep reserved bits at zero
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    release_bus();
  endtask
  task automatic read_byte(input logic [7:0] a, input logic fw, output logic [7:0] d,
                           output logic v);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    port_four_wire <= fw;
    @(posedge sys_clk);
    release_bus();
    #1;
    d = reg_rdata;
    v = reg_rd_valid;
  endtask
endmodule // pmcr_host_model

/* test/testbench.sv */
// Self-checking bench for the multiplier configuration register bank
`timescale 1ns/1ps
module testbench;
  import pmcr_pkg::*;
  logic sys_clk, sys_rst, chip_addr_seen, pll_unlocked, ref_clk_in, freq_ref_in, pll_clk_in;
  logic reg_wr, reg_rd, port_four_wire, reg_rd_valid, ratio_format_select, skip_mode_on;
  logic ref_div_tick, ref_div_code_bad, hold_active, control_port_mode;
  logic aux_out_o, aux_out_oe_n, clk_out_o, clk_out_oe_n, rv;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  logic [31:0] ratio_value;
  logic [2:0] min_loop_bw, loop_bw_applied, rmod_select;
  logic [7:0] addrs [12] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09,
                             8'h16, 8'h17, 8'h1E, 8'h0A};
  logic [7:0] ratio_bytes [4] = '{8'h2D, 8'hF5, 8'hE2, 8'h08};
  int n_mismatch = 0;
  int checks_done = 0;
  int tick_cnt = 0;
  int t0;
  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (ref_div_tick === 1'b1) tick_cnt <= tick_cnt + 1;
  pmcr_config_regs i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .port_four_wire(port_four_wire), .chip_addr_seen(chip_addr_seen),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .pll_unlocked(pll_unlocked),
    .ref_clk_in(ref_clk_in), .freq_ref_in(freq_ref_in), .pll_clk_in(pll_clk_in),
    .ratio_value(ratio_value), .ratio_format_select(ratio_format_select),
    .skip_mode_on(skip_mode_on), .min_loop_bw(min_loop_bw),
    .loop_bw_applied(loop_bw_applied), .rmod_select(rmod_select),
    .ref_div_tick(ref_div_tick), .ref_div_code_bad(ref_div_code_bad),
    .hold_active(hold_active), .control_port_mode(control_port_mode),
    .aux_out_o(aux_out_o), .aux_out_oe_n(aux_out_oe_n), .clk_out_o(clk_out_o),
    .clk_out_oe_n(clk_out_oe_n));
  pmcr_host_model i_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .port_four_wire(port_four_wire),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Pins lag the registers by one cycle, so allow three edges
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.write_byte(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_host.read_byte(a, 1'b0, rd, rv);
    chk(32'(rv), 32'h1);
    chk(32'(rd), 32'(exp));
  endtask
  task automatic ref_run(input int n);
    repeat (n) begin
      repeat (2) @(posedge sys_clk);
      ref_clk_in <= 1'b1;
      repeat (2) @(posedge sys_clk);
      ref_clk_in <= 1'b0;
    end
  endtask
  task automatic unl(input logic v);
    @(posedge sys_clk);
    pll_unlocked <= v;
    settle();
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    sys_rst = 1'b1;
    chip_addr_seen = 1'b0;
    pll_unlocked = 1'b0;
    ref_clk_in = 1'b0;
    freq_ref_in = 1'b0;
    pll_clk_in = 1'b0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    settle();
    foreach (addrs[i]) rd_chk(addrs[i], 8'h00);
    chk(ratio_value, 32'h0);
    // Bandwidth goes in before the enables so it lands before lock
    unl(1'b1);
    for (int c = 0; c < 8; c++) begin
      wr(8'h1E, 8'(c << 4));
      settle();
      chk(32'(min_loop_bw), c);
      chk(32'(loop_bw_applied), c);
    end
    unl(1'b0);
    wr(8'h1E, 8'h20);
    settle();
    chk(32'(min_loop_bw), 32'h2);
    chk(32'(loop_bw_applied), 32'h7);
    unl(1'b1);
    chk(32'(loop_bw_applied), 32'h2);
    wr(8'h03, 8'h01);
    wr(8'h05, 8'h01);
    settle();
    chk(32'(control_port_mode), 32'h0);
    @(posedge sys_clk);
    chip_addr_seen <= 1'b1;
    @(posedge sys_clk);
    chip_addr_seen <= 1'b0;
    settle();
    chk(32'(control_port_mode), 32'h1);
    wr(8'h05, 8'h00);
    settle();
    chk(32'(control_port_mode), 32'h0);
    wr(8'h03, 8'h00);
    wr(8'h05, 8'h01);
    settle();
    chk(32'(control_port_mode), 32'h0);
    wr(8'h03, 8'h01);
    settle();
    chk(32'(control_port_mode), 32'h1);
    wr(8'h05, 8'h09);
    wr(8'h03, 8'hA1);
    wr(8'h02, 8'h03);
    settle();
    chk(32'(hold_active), 32'h1);
    chk(32'(clk_out_oe_n), 32'h0);
    rd_chk(8'h02, 8'h83);
    chk(32'(rmod_select), 32'h0);
    chk(32'(aux_out_oe_n), 32'h0);
    rd_chk(8'h03, 8'hA1);
    wr(8'h05, 8'h01);
    #1;
    chk(32'(rmod_select), 32'h5);
    settle();
    chk(32'(aux_out_oe_n), 32'h1);
    chk(32'(clk_out_oe_n), 32'h1);
    wr(8'h03, 8'h61);
    #1;
    chk(32'(rmod_select), 32'h3);
    wr(8'h02, 8'h00);
    wr(8'h03, 8'h07);
    settle();
    chk(32'(aux_out_oe_n), 32'h0);
    chk(32'(clk_out_oe_n), 32'h0);
    chk(32'(aux_out_o), 32'h1);
    unl(1'b0);
    chk(32'(aux_out_o), 32'h0);
    chk(32'(aux_out_oe_n), 32'h0);
    wr(8'h16, 8'h40);
    settle();
    chk(32'(aux_out_oe_n), 32'h1);
    unl(1'b1);
    chk(32'(aux_out_o), 32'h0);
    chk(32'(aux_out_oe_n), 32'h0);
    wr(8'h03, 8'h03);
    @(posedge sys_clk);
    freq_ref_in <= 1'b1; // Slow level change, well inside the skip limits
    settle();
    chk(32'(aux_out_o), 32'h1);
    chk(32'(aux_out_oe_n), 32'h0);
    wr(8'h16, 8'hC0);
    wr(8'h17, 8'h08);
    settle();
    chk(32'(skip_mode_on), 32'h1);
    chk(32'(ratio_format_select), 32'h1);
    wr(8'h17, 8'h00);
    @(posedge sys_clk);
    pll_clk_in <= 1'b1;
    settle();
    chk(32'(ratio_format_select), 32'h0);
    chk(32'(clk_out_o), 32'h0);
    unl(1'b0);
    chk(32'(clk_out_o), 32'h1);
    wr(8'h17, 8'h10);
    unl(1'b1);
    chk(32'(clk_out_o), 32'h1);
    foreach (ratio_bytes[i]) wr(8'(8'h06 + i), ratio_bytes[i]);
    #1;
    chk(ratio_value, 32'h2DF5E208);
    rd_chk(8'h06, 8'h2D);
    rd_chk(8'h09, 8'h08);
    i_host.read_byte(8'h07, 1'b1, rd, rv);
    chk(32'(rv), 32'h0);
    wr(8'h0A, 8'hFF);
    rd_chk(8'h0A, 8'h00);
    // Warm-up edges first so a stale divider phase does not skew the count
    for (int c = 0; c < 3; c++) begin
      wr(8'h16, 8'(c << 3));
      ref_run(8);
      settle();
      t0 = tick_cnt;
      ref_run(16);
      settle();
      chk(tick_cnt - t0, 16 >> (2 - c));
    end
    wr(8'h16, 8'h18);
    settle();
    chk(32'(ref_div_code_bad), 32'h1);
    t0 = tick_cnt;
    ref_run(8);
    settle();
    chk(tick_cnt - t0, 32'h0);
    report_and_stop();
  end
endmodule // testbench
